// ==== core/ulpevr_defines.svh ====
// Contract
// RQ1 - rise enable read 0d-0f, write/set/clear
// RQ2 - five rise enables reset one, rising edge
// RQ3 - fall enables 10-12, reset one, falling edge
// RQ4 - detach source active only in host role
// RQ5 - live status 13 shows sources, upper zero
// RQ6 - latch 14 sets on enabled edge, read-clear
// RQ7 - debug 15 shows line level pair
// RQ8 - scratch 16-18 resets zero, no side effects
// RQ9 - link programs uart routes before mode select
// RQ10 - data1 held high while rx route clear
// RQ11 - switch control bits drive id, routes, left
// RQ12 - right speaker closes on right or mic
// RQ13 - uart data reaches speakers when routed
// RQ14 - link avoids uart routes during audio
// RQ15 - single-ended receivers off on audio routes
// RQ16 - accessory enable 1d, id open rise/fall
// RQ17 - unimplemented accessory bits read zero
// RQ18 - resistor done enable ored with vendor enable
// RQ19 - accessory status 20 id open, resistor code
// RQ20 - measure done clears via vendor read only
// RQ21 - accessory latch 21 id and done, read-clear
// RQ22 - mode select redefines pins, self clears
// RQ23 - weak pullup gates id open detection
// RQ24 - set address ors, clear address clears ones
// RQ25 - new latch bit reported in next rxcmd
`ifndef ULPEVR_DEFINES_SVH
`define ULPEVR_DEFINES_SVH
`define ULPEVR_A_RISE 6'h0d
`define ULPEVR_A_FALL 6'h10
`define ULPEVR_A_STAT 6'h13
`define ULPEVR_A_LATCH 6'h14
`define ULPEVR_A_DEBUG 6'h15
`define ULPEVR_A_SCRATCH 6'h16
`define ULPEVR_A_ACC_CTL 6'h19
`define ULPEVR_A_ACC_EN 6'h1d
`define ULPEVR_A_ACC_STAT 6'h20
`define ULPEVR_A_ACC_LATCH 6'h21
`define ULPEVR_RST_EDGE_EN 5'h1f
`define ULPEVR_RST_BYTE 8'h00
`define ULPEVR_ACC_CTL_MASK 8'h7e
`define ULPEVR_ACC_EN_MASK 8'h23
`define ULPEVR_B_ID_GND_DRV 1
`define ULPEVR_B_UART_TX 2
`define ULPEVR_B_UART_RX 3
`define ULPEVR_B_LEFT 4
`define ULPEVR_B_RIGHT 5
`define ULPEVR_B_MIC 6
`define ULPEVR_B_OPEN_RISE 0
`define ULPEVR_B_OPEN_FALL 1
`define ULPEVR_B_RES_IRQ 5
`endif

// ==== core/ulpevr_pkg.sv ====
package ulpevr_pkg;
  typedef enum logic [1:0] {
    ULPEVR_OP_WRITE,
    ULPEVR_OP_SET,
    ULPEVR_OP_CLEAR,
    ULPEVR_OP_NONE
  } ulpevr_op_t;
endpackage : ulpevr_pkg

// ==== core/ulpevr_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ulpevr_defines.svh"
module ulpevr_regs
  import ulpevr_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // register access from the ulpi front end
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_hit,
  // analog event sources, asynchronous
  input wire logic [4:0] i_event_src,
  input wire logic [1:0] i_line_level_pair,
  input wire logic i_id_open_raw,
  // resistor measurement engine
  input wire logic i_resistor_measure_done,
  input wire logic [2:0] i_id_resistor_code,
  input wire logic i_vendor_res_irq_enable,
  // other registers of the device
  input wire logic i_host_role,
  input wire logic i_accessory_mode_select,
  input wire logic i_id_pin_weak_pullup,
  // uart pins in accessory mode
  input wire logic i_uart_txd,
  input wire logic i_dp_level,
  // switches and pin controls
  output logic o_id_ground_drive,
  output logic o_dm_from_txd,
  output logic o_dp_to_rxd,
  output logic o_left_speaker_switch,
  output logic o_right_speaker_switch,
  output logic o_se_receiver_disable,
  output logic o_data1_out,
  output logic o_data1_oe,
  output logic o_data0_oe,
  // uart data for the speaker pins
  output logic o_left_speaker_uart,
  output logic o_right_speaker_uart,
  // rxcmd notification
  output logic o_alt_int,
  output logic o_event_notify
);
  // ************************************
  // state
  // ************************************
  typedef struct packed {
    logic [4:0] src_s1;
    logic [4:0] src_s2;
    logic [4:0] src_prev;
    logic [1:0] line_s1;
    logic [1:0] line_s2;
    logic open_s1;
    logic open_s2;
    logic open_prev;
    logic done_s1;
    logic done_s2;
    logic done_prev;
    logic [4:0] latch;
    logic acc_open_latch;
    logic acc_done_latch;
    logic [7:0] rdata;
    logic alt_int;
    logic notify;
  } ulpevr_st_t;
  ulpevr_st_t st_ff;
  ulpevr_st_t nxt_st;
  // ************************************
  // write, set and clear registers
  // ************************************
  logic [7:0] rise_en;
  logic [7:0] fall_en;
  logic [7:0] scratch;
  logic [7:0] acc_ctl;
  logic [7:0] acc_en;
  logic [5:0] base_rise;
  logic [5:0] base_fall;
  logic [5:0] base_scr;
  logic [5:0] base_ctl;
  logic [5:0] base_en;
  ulpevr_op_t op_rise;
  ulpevr_op_t op_fall;
  ulpevr_op_t op_scr;
  ulpevr_op_t op_ctl;
  ulpevr_op_t op_en;
  function automatic ulpevr_op_t op_of(input logic [5:0] addr, input logic [5:0] base);
    logic [5:0] diff;
    diff = addr - base;
    case (diff)
      6'h00: op_of = ULPEVR_OP_WRITE;
      6'h01: op_of = ULPEVR_OP_SET;
      6'h02: op_of = ULPEVR_OP_CLEAR;
      default: op_of = ULPEVR_OP_NONE;
    endcase
  endfunction : op_of
  assign base_rise = `ULPEVR_A_RISE;
  assign base_fall = `ULPEVR_A_FALL;
  assign base_scr = `ULPEVR_A_SCRATCH;
  assign base_ctl = `ULPEVR_A_ACC_CTL;
  assign base_en = `ULPEVR_A_ACC_EN;
  // RQ1 rise window decode
  assign op_rise = op_of(i_reg_addr, base_rise);
  // RQ3 fall window decode
  assign op_fall = op_of(i_reg_addr, base_fall);
  assign op_scr = op_of(i_reg_addr, base_scr);
  assign op_ctl = op_of(i_reg_addr, base_ctl);
  assign op_en = op_of(i_reg_addr, base_en);
  // RQ2 rise enables reset one
  ulpevr_wsc_reg #(
    .RST({3'h0, `ULPEVR_RST_EDGE_EN}),
    .MASK(8'h1f)
  ) u_rise (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_hit(i_reg_wr),
    .i_op(op_rise),
    .i_wdata(i_reg_wdata),
    .o_value(rise_en)
  );
  // RQ3 fall enables reset one
  ulpevr_wsc_reg #(
    .RST({3'h0, `ULPEVR_RST_EDGE_EN}),
    .MASK(8'h1f)
  ) u_fall (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_hit(i_reg_wr),
    .i_op(op_fall),
    .i_wdata(i_reg_wdata),
    .o_value(fall_en)
  );
  // RQ8 scratch, drives nothing
  ulpevr_wsc_reg #(
    .RST(`ULPEVR_RST_BYTE),
    .MASK(8'hff)
  ) u_scr (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_hit(i_reg_wr),
    .i_op(op_scr),
    .i_wdata(i_reg_wdata),
    .o_value(scratch)
  );
  // RQ11 bit 0 and 7 held zero
  ulpevr_wsc_reg #(
    .RST(`ULPEVR_RST_BYTE),
    .MASK(`ULPEVR_ACC_CTL_MASK)
  ) u_ctl (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_hit(i_reg_wr),
    .i_op(op_ctl),
    .i_wdata(i_reg_wdata),
    .o_value(acc_ctl)
  );
  // RQ17 unimplemented enables masked
  ulpevr_wsc_reg #(
    .RST(`ULPEVR_RST_BYTE),
    .MASK(`ULPEVR_ACC_EN_MASK)
  ) u_en (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_hit(i_reg_wr),
    .i_op(op_en),
    .i_wdata(i_reg_wdata),
    .o_value(acc_en)
  );
  // ************************************
  // edge detection and latches
  // ************************************
  logic [4:0] src_live;
  logic [4:0] edge_hit;
  logic open_now;
  logic open_edge;
  logic res_irq_en;
  logic done_rise;
  logic rd_latch;
  logic rd_acc_latch;
  logic [7:0] rd_mux;
  // RQ4 detach gated by host role
  assign src_live = {st_ff.src_s2[4:1], st_ff.src_s2[0] & i_host_role};
  // RQ23 open only with pullup
  assign open_now = st_ff.open_s2 & i_id_pin_weak_pullup;
  // RQ18 enable ored with vendor
  assign res_irq_en = acc_en[`ULPEVR_B_RES_IRQ] | i_vendor_res_irq_enable;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_edge
      // RQ2 rising edge qualify
      assign edge_hit[gi] = (rise_en[gi] & src_live[gi] & ~st_ff.src_prev[gi])
        // RQ3 falling edge qualify
        | (fall_en[gi] & ~src_live[gi] & st_ff.src_prev[gi]);
    end
  endgenerate
  // RQ16 id open direction enables
  assign open_edge = (acc_en[`ULPEVR_B_OPEN_RISE] & open_now & ~st_ff.open_prev)
    | (acc_en[`ULPEVR_B_OPEN_FALL] & ~open_now & st_ff.open_prev);
  // RQ21 done rises while enabled
  assign done_rise = res_irq_en & st_ff.done_s2 & ~st_ff.done_prev;
  assign rd_latch = i_reg_rd && (i_reg_addr == `ULPEVR_A_LATCH);
  assign rd_acc_latch = i_reg_rd && (i_reg_addr == `ULPEVR_A_ACC_LATCH);
  // ************************************
  // read mux
  // ************************************
  always_comb begin
    rd_mux = 8'h00;
    o_reg_hit = 1'b1;
    if (op_rise != ULPEVR_OP_NONE) begin
      rd_mux = rise_en;
    end else if (op_fall != ULPEVR_OP_NONE) begin
      rd_mux = fall_en;
    end else if (op_scr != ULPEVR_OP_NONE) begin
      rd_mux = scratch;
    end else if (op_ctl != ULPEVR_OP_NONE) begin
      rd_mux = acc_ctl;
    end else if (op_en != ULPEVR_OP_NONE) begin
      rd_mux = acc_en;
    end else begin
      case (i_reg_addr)
        // RQ5 live sources, upper zero
        `ULPEVR_A_STAT: rd_mux = {3'h0, src_live};
        // RQ6 latched bits
        `ULPEVR_A_LATCH: rd_mux = {3'h0, st_ff.latch};
        // RQ7 line level pair
        `ULPEVR_A_DEBUG: rd_mux = {6'h00, st_ff.line_s2};
        // RQ19 open, code and done
        // RQ20 reading here keeps done
        `ULPEVR_A_ACC_STAT: rd_mux = {1'b0, st_ff.done_s2, i_id_resistor_code, 2'b00, open_now};
        // RQ21 accessory latch bits
        `ULPEVR_A_ACC_LATCH: rd_mux = {4'h0, st_ff.acc_done_latch, 2'b00, st_ff.acc_open_latch};
        default: begin
          rd_mux = 8'h00;
          o_reg_hit = 1'b0;
        end
      endcase
    end
  end
  // ************************************
  // next state
  // ************************************
  always_comb begin
    nxt_st = st_ff;
    // two-flop sync of event, line, id open and done inputs
    nxt_st.src_s1 = i_event_src;
    nxt_st.src_s2 = st_ff.src_s1;
    nxt_st.src_prev = src_live;
    nxt_st.line_s1 = i_line_level_pair;
    nxt_st.line_s2 = st_ff.line_s1;
    nxt_st.open_s1 = i_id_open_raw;
    nxt_st.open_s2 = st_ff.open_s1;
    nxt_st.open_prev = open_now;
    nxt_st.done_s1 = i_resistor_measure_done;
    nxt_st.done_s2 = st_ff.done_s1;
    nxt_st.done_prev = st_ff.done_s2;
    // RQ6 read clears, new edge wins
    nxt_st.latch = (rd_latch ? 5'h00 : st_ff.latch) | edge_hit;
    // RQ21 read clears, set wins
    nxt_st.acc_open_latch = (~rd_acc_latch & st_ff.acc_open_latch) | open_edge;
    nxt_st.acc_done_latch = (~rd_acc_latch & st_ff.acc_done_latch) | done_rise;
    if (i_reg_rd) begin
      nxt_st.rdata = rd_mux;
    end
    // RQ25 new latch event to rxcmd
    nxt_st.notify = (|edge_hit) | open_edge | done_rise;
    // RQ16 alt_int for accessory events
    nxt_st.alt_int = open_edge | done_rise;
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ************************************
  // switches and pins
  // ************************************
  logic acc_on;
  logic audio_on;
  // RQ22 mode gates data1 enable and speaker uart, not switches
  assign acc_on = i_accessory_mode_select;
  assign audio_on = acc_ctl[`ULPEVR_B_LEFT] | acc_ctl[`ULPEVR_B_RIGHT] | acc_ctl[`ULPEVR_B_MIC];
  // RQ11 control bits to switches
  assign o_id_ground_drive = acc_ctl[`ULPEVR_B_ID_GND_DRV];
  assign o_dm_from_txd = acc_ctl[`ULPEVR_B_UART_TX];
  assign o_dp_to_rxd = acc_ctl[`ULPEVR_B_UART_RX];
  assign o_left_speaker_switch = acc_ctl[`ULPEVR_B_LEFT];
  // RQ12 right on either bit
  assign o_right_speaker_switch = acc_ctl[`ULPEVR_B_RIGHT] | acc_ctl[`ULPEVR_B_MIC];
  // RQ15 receivers off for audio
  assign o_se_receiver_disable = audio_on;
  // RQ10 data1 high without rx route
  assign o_data1_out = acc_ctl[`ULPEVR_B_UART_RX] ? i_dp_level : 1'b1;
  assign o_data1_oe = acc_on;
  assign o_data0_oe = 1'b0;
  // RQ13 uart data on speaker pins
  assign o_left_speaker_uart = acc_on & acc_ctl[`ULPEVR_B_UART_TX]
    & acc_ctl[`ULPEVR_B_LEFT] & i_uart_txd;
  assign o_right_speaker_uart = acc_on & acc_ctl[`ULPEVR_B_UART_RX]
    & o_right_speaker_switch & i_dp_level;
  assign o_reg_rdata = st_ff.rdata;
  assign o_alt_int = st_ff.alt_int;
  assign o_event_notify = st_ff.notify;
endmodule : ulpevr_regs
`default_nettype wire

// ==== core/ulpevr_wsc_reg.sv ====
`timescale 1ns/10ps
`default_nettype none
// one byte register with write, set and clear ports
module ulpevr_wsc_reg
  import ulpevr_pkg::*;
#(
  parameter logic [7:0] RST = 8'h00,
  parameter logic [7:0] MASK = 8'hff
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // access
  input wire logic i_hit,
  input wire ulpevr_op_t i_op,
  input wire logic [7:0] i_wdata,
  // value
  output logic [7:0] o_value
);
  typedef struct packed {
    logic [7:0] value;
  } ulpevr_wsc_st_t;
  ulpevr_wsc_st_t st_ff;
  ulpevr_wsc_st_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (i_hit) begin
      // RQ24 set and clear
      case (i_op)
        ULPEVR_OP_WRITE: nxt_st.value = i_wdata & MASK;
        ULPEVR_OP_SET: nxt_st.value = (st_ff.value | i_wdata) & MASK;
        ULPEVR_OP_CLEAR: nxt_st.value = st_ff.value & ~i_wdata;
        default: nxt_st.value = st_ff.value;
      endcase
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_ff.value <= RST;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign o_value = st_ff.value;
endmodule : ulpevr_wsc_reg
`default_nettype wire

// ==== verif/ulpevr_link_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ulpevr_link_model (
  // clock
  input wire logic i_clk_sys,
  // requests from the bench
  input wire logic i_go,
  input wire logic i_wr,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_mode_req,
  // register port toward the block
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [5:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_mode_sel
);
  logic routed_ff;
  initial begin
    {o_reg_wr, o_reg_rd, o_reg_addr, o_reg_wdata, o_mode_sel, routed_ff} = '0;
  end
  always @(posedge i_clk_sys) begin
    o_reg_wr <= i_go & i_wr;
    o_reg_rd <= i_go & ~i_wr;
    // idle lines toggle so stale values are never trusted
    o_reg_addr <= i_go ? i_addr : ~o_reg_addr;
    o_reg_wdata <= i_go ? i_wdata : ~o_reg_wdata;
    if (i_go & i_wr & (i_addr == 6'h19)) begin
      routed_ff <= 1'b1;
    end
    o_mode_sel <= i_mode_req & routed_ff;
  end
endmodule : ulpevr_link_model
`default_nettype wire

// ==== verif/ulpevr_regs_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module ulpevr_regs_assertions (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // register access
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_hit,
  // pin side
  input wire logic [2:0] i_id_resistor_code,
  input wire logic i_accessory_mode_select,
  input wire logic i_uart_txd,
  input wire logic i_dp_level,
  input wire logic o_dm_from_txd,
  input wire logic o_dp_to_rxd,
  input wire logic o_left_speaker_switch,
  input wire logic o_right_speaker_switch,
  input wire logic o_se_receiver_disable,
  input wire logic o_data1_out,
  input wire logic o_data1_oe,
  input wire logic o_left_speaker_uart,
  input wire logic o_event_notify
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);
  // write data one cycle back, for the write checks
  logic [7:0] wd_q;
  always_ff @(posedge i_clk_sys) begin
    wd_q <= i_reg_wdata;
  end
  sequence s_rd(logic [5:0] a);
    i_reg_rd && i_reg_addr == a;
  endsequence
  sequence s_wr(logic [5:0] a);
    i_reg_wr && i_reg_addr == a;
  endsequence
  // ************************************************
  // assertions
  // ************************************************
  AST_DATA1_HIGH: assert property (!o_dp_to_rxd |-> o_data1_out)
    else $error("data1 not high with rx route off");
  AST_DATA1_RX: assert property (o_dp_to_rxd |-> o_data1_out == i_dp_level)
    else $error("data1 does not follow dp");
  AST_RCV_OFF: assert property (o_se_receiver_disable == (o_left_speaker_switch | o_right_speaker_switch))
    else $error("receiver disable wrong");
  AST_OE_MODE: assert property (o_data1_oe == i_accessory_mode_select)
    else $error("data1 enable wrong");
  AST_UART_LEFT: assert property (i_accessory_mode_select && o_dm_from_txd && o_left_speaker_switch |-> o_left_speaker_uart == i_uart_txd)
    else $error("left speaker uart data wrong");
  AST_STAT_TOP: assert property (s_rd(6'h13) |=> o_reg_rdata[7:5] == 3'h0)
    else $error("status upper bits set");
  AST_RES_CODE: assert property (s_rd(6'h20) |=> o_reg_rdata[5:3] == $past(i_id_resistor_code) && !o_reg_rdata[7])
    else $error("resistor code wrong");
  AST_CTL_WR: assert property (s_wr(6'h19) |=> o_left_speaker_switch == wd_q[4] && o_dm_from_txd == wd_q[2])
    else $error("control write not applied");
  AST_CTL_CLR: assert property (s_wr(6'h1b) |=> !wd_q[3] || !o_dp_to_rxd)
    else $error("control clear not applied");
  AST_LATCH_CLR: assert property (s_rd(6'h14) ##1 !o_event_notify ##1 (s_rd(6'h14) and !o_event_notify) ##1 !o_event_notify |-> o_reg_rdata == 8'h00)
    else $error("latch not cleared by read");
  AST_HIT_GAP: assert property (s_rd(6'h3c) |-> !o_reg_hit)
    else $error("unmapped address reported as mapped");
  AST_HIT_MAP: assert property (s_rd(6'h14) |-> o_reg_hit)
    else $error("latch address reported as unmapped");
endmodule : ulpevr_regs_assertions
bind ulpevr_regs ulpevr_regs_assertions i_chk (.*);
`default_nettype wire

// ==== verif/ulpevr_regs_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module ulpevr_regs_test;
  logic clk = 0, rst_n = 0, go = 0, wr = 0, mreq = 0;
  logic [5:0] addr = 0;
  logic [7:0] wd = 0, r, s;
  logic [4:0] src = 0;
  logic [1:0] lp = 0;
  logic [2:0] code = 0;
  logic opn = 0, done = 0, ven = 0, host = 1, pu = 0, txd = 0, dpl = 0;
  logic bwr, brd, msel, hit, idg, dmt, dpr, lsw, rsw, sed, d1, d1oe, d0oe, lu, ru, alt, ev;
  logic [5:0] baddr;
  logic [7:0] bwd, rdata;
  logic [7:0] q[$];
  logic [31:0] seed = 32'ha43a0b12;
  logic pend = 0, alt_seen = 0, ev_seen = 0;
  int err_count = 0, cmp_count = 0;
  ulpevr_link_model i_ulpevr_link_model (.i_clk_sys(clk), .i_go(go), .i_wr(wr),
    .i_addr(addr), .i_wdata(wd), .i_mode_req(mreq), .o_reg_wr(bwr), .o_reg_rd(brd),
    .o_reg_addr(baddr), .o_reg_wdata(bwd), .o_mode_sel(msel));
  ulpevr_regs i_ulpevr_regs (.i_clk_sys(clk), .i_reset_n(rst_n), .i_reg_wr(bwr),
    .i_reg_rd(brd), .i_reg_addr(baddr), .i_reg_wdata(bwd), .o_reg_rdata(rdata),
    .o_reg_hit(hit), .i_event_src(src), .i_line_level_pair(lp), .i_id_open_raw(opn),
    .i_resistor_measure_done(done), .i_id_resistor_code(code),
    .i_vendor_res_irq_enable(ven), .i_host_role(host), .i_accessory_mode_select(msel),
    .i_id_pin_weak_pullup(pu), .i_uart_txd(txd), .i_dp_level(dpl), .o_id_ground_drive(idg),
    .o_dm_from_txd(dmt), .o_dp_to_rxd(dpr), .o_left_speaker_switch(lsw),
    .o_right_speaker_switch(rsw), .o_se_receiver_disable(sed), .o_data1_out(d1),
    .o_data1_oe(d1oe), .o_data0_oe(d0oe), .o_left_speaker_uart(lu),
    .o_right_speaker_uart(ru), .o_alt_int(alt), .o_event_notify(ev));
  initial begin
    forever #4 clk = ~clk;
  end
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wrap_up;
    $display("mismatches=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    go <= 1;
    wr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    go <= 0;
  endtask : acc
  task rd(input logic [5:0] a, input logic [7:0] e);
    q.push_back(e);
    acc(0, a, 8'h00);
  endtask : rd
  task settle;
    repeat (8) @(posedge clk);
  endtask : settle
  // ************************************************
  // result watcher
  // ************************************************
  always @(posedge clk) begin
    pend <= brd;
    if (alt === 1'b1) alt_seen <= 1;
    if (ev === 1'b1) ev_seen <= 1;
  end
  always @(negedge clk) begin
    if (pend) begin
      if (q.size() == 0) chk(8'hee, 8'h00);
      else chk(rdata, q.pop_front());
    end
  end
  // watchdog, one miss then report
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    rd(6'h0d, 8'h1f);
    rd(6'h12, 8'h1f);
    rd(6'h13, 8'h00);
    rd(6'h14, 8'h00);
    rd(6'h16, 8'h00);
    rd(6'h1b, 8'h00);
    rd(6'h21, 8'h00);
    rd(6'h3c, 8'h00);
    acc(1, 6'h0d, 8'hff);
    acc(1, 6'h0f, 8'h05);
    acc(1, 6'h0e, 8'h01);
    rd(6'h0e, 8'h1b);
    acc(1, 6'h10, 8'h00);
    acc(1, 6'h11, 8'h12);
    rd(6'h10, 8'h12);
    r = rnd();
    s = rnd();
    acc(1, 6'h16, r);
    acc(1, 6'h17, s);
    acc(1, 6'h18, 8'h0f);
    rd(6'h17, (r | s) & 8'hf0);
    rd(6'h0f, 8'h1b);
    src <= 5'h1f;
    settle();
    rd(6'h13, 8'h1f);
    rd(6'h14, 8'h1b);
    rd(6'h14, 8'h00);
    chk({7'h0, ev_seen}, 8'h01);
    src <= 5'h00;
    settle();
    rd(6'h14, 8'h12);
    host <= 0;
    src <= 5'h01;
    settle();
    rd(6'h13, 8'h00);
    rd(6'h14, 8'h00);
    r = rnd();
    lp <= r[1:0];
    settle();
    rd(6'h15, {6'h00, r[1:0]});
    acc(1, 6'h19, 8'hff);
    rd(6'h1a, 8'h7e);
    chk({4'h0, idg, dmt, dpr, lsw}, 8'h0f);
    chk({7'h0, sed}, 8'h01);
    for (int v = 0; v < 4; v++) begin
      acc(1, 6'h19, {1'b0, v[1:0], 5'h00});
      settle();
      chk({7'h0, rsw}, {7'h0, |v[1:0]});
    end
    // no right or mic route with uart
    acc(1, 6'h19, 8'h1c);
    mreq <= 1;
    txd <= r[2];
    dpl <= r[3];
    settle();
    chk({7'h0, d1oe}, 8'h01);
    chk({7'h0, lu}, {7'h0, r[2]});
    chk({7'h0, ru}, 8'h00);
    chk({7'h0, d0oe}, 8'h00);
    chk({7'h0, idg}, 8'h00);
    acc(1, 6'h1b, 8'h08);
    settle();
    chk({7'h0, d1}, 8'h01);
    mreq <= 0;
    acc(1, 6'h1d, 8'hff);
    rd(6'h1f, 8'h23);
    pu <= 1;
    code <= 3'b011;
    opn <= 1;
    done <= 1;
    settle();
    rd(6'h20, 8'h59);
    rd(6'h21, 8'h09);
    rd(6'h21, 8'h00);
    chk({7'h0, alt_seen}, 8'h01);
    acc(1, 6'h1f, 8'h20);
    done <= 0;
    settle();
    ven <= 1;
    done <= 1;
    settle();
    rd(6'h21, 8'h08);
    settle();
    wrap_up();
  end
endmodule : ulpevr_regs_test
`default_nettype wire
